// ### hw/ddrc_pkg.sv
// ddrc_pkg: shared constants, command and state types for the cke/command pair
// assumes a single clock domain; pins are sampled on the rising edge
package ddrc_pkg;
  localparam int BANK_W = 3;
  localparam int COL_W = 2;
  localparam int DATA_W = 8;
  localparam int BURST_LEN = 4;
  localparam int BURST_NO_INTERRUPT = 4;
  localparam int MIN_CKE_PULSE = 3;
  localparam int READ_EXIT_CLOCKS = 200;
  localparam int NONREAD_EXIT_CLOCKS = 16;
  localparam int OP_BUSY_CLOCKS = 2;
  localparam int MAX_POWER_DOWN = 1000;
  localparam int CNT_W = 16;
  localparam logic [3:0] PINS_DESELECT = 4'h8;
  localparam logic [3:0] PINS_NOP = 4'h7;
  localparam logic RST_CKE = 1'b1;

  // command as seen on cs/ras/cas/we
  typedef enum logic [2:0] {
    DDRC_CMD_DESEL, DDRC_CMD_NOP, DDRC_CMD_READ, DDRC_CMD_WRITE,
    DDRC_CMD_ACT, DDRC_CMD_PRE, DDRC_CMD_REF, DDRC_CMD_MRS
  } ddrc_cmd_t;

  // device state
  typedef enum logic [2:0] {
    DDRC_IDLE, DDRC_ACTIVE, DDRC_READ, DDRC_WRITE,
    DDRC_PD_ACT, DDRC_PD_PRE, DDRC_SELF
  } ddrc_state_t;

  // pins {csN, rasN, casN, weN} to command
  function automatic ddrc_cmd_t ddrc_decode(input logic [3:0] p);
    ddrc_cmd_t c;
    c = DDRC_CMD_DESEL;
    if (!p[3]) begin
      case (p[2:0])
        3'h7: c = DDRC_CMD_NOP;
        3'h5: c = DDRC_CMD_READ;
        3'h4: c = DDRC_CMD_WRITE;
        3'h3: c = DDRC_CMD_ACT;
        3'h2: c = DDRC_CMD_PRE;
        3'h1: c = DDRC_CMD_REF;
        default: c = DDRC_CMD_MRS;
      endcase
    end
    return c;
  endfunction : ddrc_decode

  // command to pins {csN, rasN, casN, weN}
  function automatic logic [3:0] ddrc_encode(input ddrc_cmd_t c);
    logic [3:0] p;
    p = PINS_DESELECT;
    case (c)
      DDRC_CMD_NOP: p = PINS_NOP;
      DDRC_CMD_READ: p = 4'h5;
      DDRC_CMD_WRITE: p = 4'h4;
      DDRC_CMD_ACT: p = 4'h3;
      DDRC_CMD_PRE: p = 4'h2;
      DDRC_CMD_REF: p = 4'h1;
      DDRC_CMD_MRS: p = 4'h0;
      default: p = PINS_DESELECT;
    endcase
    return p;
  endfunction : ddrc_encode
endpackage : ddrc_pkg

// ### hw/ddrc_if.sv
// ddrc_if: command, clock-enable and data pins between controller and device
// assumes both ends share clk; no clocking block
`timescale 1ns/10ps
interface ddrc_if;
  import ddrc_pkg::*;
  logic cke;
  logic [3:0] cmdPins;
  logic [BANK_W-1:0] bank;
  logic a10;
  logic [COL_W-1:0] col;
  logic [DATA_W-1:0] dq;
  logic dm;
  logic odt;
  logic [DATA_W-1:0] rdq;
  logic rdqValid;
  modport dev (
    input cke, cmdPins, bank, a10, col, dq, dm, odt,
    output rdq, rdqValid
  );
  modport ctl (
    output cke, cmdPins, bank, a10, col, dq, dm, odt,
    input rdq, rdqValid
  );
endinterface : ddrc_if

// ### hw/ddrc_device.sv
// ddrc_device: device end; cke transitions, bank state, bursts and masked store
// assumes the controller keeps its own timing; illegal input raises a flag
//
// Contract
// - transition from cke now, cke before, command
// - cke low twice keeps power down/self refresh
// - power down in/out only with nop/deselect
// - self refresh entry from idle with refresh
// - self refresh exit with nop/deselect only
// - nop/deselect only during non-read exit delay
// - no read for 200 clocks after exit
// - no low power during busy operations
// - cke held three edges after change
// - transitions ignore termination; off in self refresh
// - power down time limited for refresh
// - cke high during impedance calibration; calMode only blocks entry, a power down already under way is not left
// - termination pin valid during power down
// - unlisted combinations never issued
// - mask high inhibits store of beat
// - idle command table
// - banks-active command table
// - burst command table and interrupts
// - command decoded from four pins at edge
// - length-four bursts never interrupted
`timescale 1ns/10ps
module ddrc_device
  import ddrc_pkg::*;
#(
  parameter int BURST = BURST_LEN
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic en,
  ddrc_if.dev ifc,
  output ddrc_state_t devState,
  output logic illegalCmd,
  output logic odtActive
);
  localparam int BANKS = 1 << BANK_W;
  localparam int WORDS = BANKS << COL_W;
  localparam int BEAT_W = $clog2(BURST) + 1;
  localparam logic [BEAT_W-1:0] LAST_BEAT = BEAT_W'(BURST - 1);

  typedef struct packed {
    logic ckePrev;
    ddrc_state_t st;
    logic [BANKS-1:0] open;
    logic [BANK_W-1:0] bBank;
    logic [COL_W-1:0] bCol;
    logic [BEAT_W-1:0] beat;
    logic illegal;
    logic odtOn;
    logic [DATA_W-1:0] rdq;
    logic rdqValid;
    logic [WORDS-1:0][DATA_W-1:0] mem;
  } ddrc_dev_t;

  ddrc_dev_t q;
  ddrc_dev_t d;
  ddrc_cmd_t cmd;
  logic quiet;
  logic [BANK_W+COL_W-1:0] idx;

  assign cmd = ddrc_decode(ifc.cmdPins);
  assign quiet = (cmd == DDRC_CMD_DESEL) || (cmd == DDRC_CMD_NOP);
  assign idx = {q.bBank, q.bCol + q.beat[COL_W-1:0]};

  // next state from cke pair, command and current state
  always_comb begin
    d = q;
    if (en) begin
      d.illegal = 1'b0;
      d.rdqValid = 1'b0;
      d.ckePrev = ifc.cke;
      // one data beat per cycle while a burst runs
      if (q.st == DDRC_WRITE && !ifc.dm) begin
        d.mem[idx] = ifc.dq;
      end
      if (q.st == DDRC_READ) begin
        d.rdq = q.mem[idx];
        d.rdqValid = 1'b1;
      end
      case ({q.ckePrev, ifc.cke})
        2'b00: begin
          // stay whatever the command pins show
          if (q.st != DDRC_PD_ACT && q.st != DDRC_PD_PRE && q.st != DDRC_SELF) begin
            d.illegal = 1'b1;
          end
        end
        2'b01: begin
          d.illegal = !quiet;
          case (q.st)
            DDRC_PD_ACT: d.st = DDRC_ACTIVE;
            DDRC_PD_PRE: d.st = DDRC_IDLE;
            DDRC_SELF: d.st = DDRC_IDLE;
            default: d.illegal = 1'b1;
          endcase
        end
        2'b10: begin
          if (q.st == DDRC_IDLE && cmd == DDRC_CMD_REF) begin
            d.st = DDRC_SELF;
          end else if (quiet && q.st == DDRC_IDLE) begin
            d.st = DDRC_PD_PRE;
          end else if (quiet && q.st == DDRC_ACTIVE) begin
            d.st = DDRC_PD_ACT;
          end else begin
            d.illegal = 1'b1; // busy bursts block entry
          end
        end
        default: begin
          case (q.st)
            DDRC_IDLE: begin
              case (cmd)
                DDRC_CMD_ACT: begin
                  d.open[ifc.bank] = 1'b1;
                  d.st = DDRC_ACTIVE;
                end
                DDRC_CMD_READ, DDRC_CMD_WRITE: d.illegal = 1'b1;
                default: d.st = DDRC_IDLE;
              endcase
            end
            DDRC_ACTIVE: begin
              case (cmd)
                DDRC_CMD_READ, DDRC_CMD_WRITE: begin
                  if (q.open[ifc.bank]) begin
                    d.st = (cmd == DDRC_CMD_READ) ? DDRC_READ : DDRC_WRITE;
                    d.bBank = ifc.bank;
                    d.bCol = ifc.col;
                    d.beat = '0;
                  end else begin
                    d.illegal = 1'b1;
                  end
                end
                DDRC_CMD_ACT: begin
                  if (q.open[ifc.bank]) begin
                    d.illegal = 1'b1;
                  end else begin
                    d.open[ifc.bank] = 1'b1;
                  end
                end
                DDRC_CMD_PRE: begin
                  if (ifc.a10) begin
                    d.open = '0;
                  end else begin
                    d.open[ifc.bank] = 1'b0;
                  end
                  if (d.open == '0) begin
                    d.st = DDRC_IDLE;
                  end
                end
                DDRC_CMD_REF, DDRC_CMD_MRS: d.illegal = 1'b1;
                default: d.st = DDRC_ACTIVE;
              endcase
            end
            DDRC_READ, DDRC_WRITE: begin
              // burst runs to its end unless a same-direction command cuts in
              if (q.beat == LAST_BEAT) begin
                d.st = DDRC_ACTIVE;
              end else begin
                d.beat = q.beat + 1'b1;
              end
              case (cmd)
                DDRC_CMD_DESEL, DDRC_CMD_NOP: d.illegal = 1'b0;
                DDRC_CMD_READ, DDRC_CMD_WRITE: begin
                  if ((cmd == DDRC_CMD_READ) != (q.st == DDRC_READ)) begin
                    d.illegal = 1'b1;
                  end else if (BURST <= BURST_NO_INTERRUPT || !q.open[ifc.bank]) begin
                    d.illegal = 1'b1;
                  end else begin
                    d.st = q.st;
                    d.bBank = ifc.bank;
                    d.bCol = ifc.col;
                    d.beat = '0;
                  end
                end
                DDRC_CMD_ACT: begin
                  if (ifc.bank == q.bBank || q.open[ifc.bank]) begin
                    d.illegal = 1'b1;
                  end else begin
                    d.open[ifc.bank] = 1'b1;
                  end
                end
                DDRC_CMD_PRE: begin
                  if (ifc.a10 || ifc.bank == q.bBank) begin
                    d.illegal = 1'b1;
                  end else begin
                    d.open[ifc.bank] = 1'b0;
                  end
                end
                default: d.illegal = 1'b1;
              endcase
            end
            default: d.illegal = 1'b1; // cke high twice in low power
          endcase
        end
      endcase
      // termination follows its pin except in self refresh
      d.odtOn = ifc.odt && d.st != DDRC_SELF;
    end
  end

  // state register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
      q.ckePrev <= RST_CKE;
      q.st <= DDRC_IDLE;
    end else begin
      q <= d;
    end
  end

  assign devState = q.st;
  assign illegalCmd = q.illegal;
  assign odtActive = q.odtOn;
  assign ifc.rdq = q.rdq;
  assign ifc.rdqValid = q.rdqValid;
endmodule : ddrc_device

// ### hw/ddrc_controller.sv
// ddrc_controller: controller end; drives cke, commands and write data
// assumes user requests are synchronous to clk; refused requests simply wait
`timescale 1ns/10ps
module ddrc_controller
  import ddrc_pkg::*;
#(
  parameter int BURST = BURST_LEN,
  parameter int NONREAD_EXIT = NONREAD_EXIT_CLOCKS,
  parameter int MAX_PD = MAX_POWER_DOWN
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic en,
  ddrc_if.ctl ifc,
  input wire logic reqValid,
  input wire ddrc_cmd_t reqCmd,
  input wire logic [BANK_W-1:0] reqBank,
  input wire logic reqA10,
  input wire logic [COL_W-1:0] reqCol,
  input wire logic reqLowPower,
  input wire logic reqSelfRefresh,
  input wire logic calMode,
  input wire logic odtReq,
  input wire logic [DATA_W-1:0] wrData,
  input wire logic wrMask,
  output logic reqAck,
  output logic burstBusy,
  output logic lowPower
);
  localparam int BANKS = 1 << BANK_W;

  typedef struct packed {
    logic cke;
    logic [3:0] pins;
    logic [BANK_W-1:0] bank;
    logic a10;
    logic [COL_W-1:0] col;
    logic [DATA_W-1:0] dq;
    logic dm;
    logic odt;
    logic ack;
    logic inSelf;
    logic writing;
    logic [BANK_W-1:0] bBank;
    logic busy;
    logic lowP;
    logic [BANKS-1:0] open;
    logic [CNT_W-1:0] pulse;
    logic [CNT_W-1:0] exitCnt;
    logic [CNT_W-1:0] pdCnt;
    logic [CNT_W-1:0] opBusy;
    logic [CNT_W-1:0] left;
  } ddrc_ctl_t;

  ddrc_ctl_t q;
  ddrc_ctl_t d;
  logic pulseOk;
  logic ok;
  logic rd;

  assign pulseOk = q.pulse >= CNT_W'(MIN_CKE_PULSE - 1);
  assign rd = reqCmd == DDRC_CMD_READ;

  // legality of the user's command against the tracked state
  always_comb begin
    ok = q.exitCnt == '0 || (!rd && q.exitCnt <= CNT_W'(READ_EXIT_CLOCKS - NONREAD_EXIT));
    case (reqCmd)
      DDRC_CMD_READ, DDRC_CMD_WRITE: begin
        ok = ok && q.open[reqBank];
        if (q.left != '0) begin
          ok = ok && (rd != q.writing) && BURST > BURST_NO_INTERRUPT;
        end
      end
      DDRC_CMD_ACT: ok = ok && !q.open[reqBank] && !(q.left != '0 && reqBank == q.bBank);
      DDRC_CMD_PRE: ok = ok && (q.left == '0 || (!reqA10 && reqBank != q.bBank));
      DDRC_CMD_REF, DDRC_CMD_MRS: ok = ok && q.open == '0 && q.left == '0;
      default: ok = 1'b0;
    endcase
    ok = ok && reqValid && q.cke;
  end

  // next state of pins and trackers
  always_comb begin
    d = q;
    if (en) begin
      d.pins = PINS_NOP;
      d.ack = 1'b0;
      d.odt = odtReq; // always a valid level
      d.pulse = pulseOk ? q.pulse : q.pulse + 1'b1;
      d.exitCnt = (q.exitCnt == '0) ? '0 : q.exitCnt - 1'b1;
      d.opBusy = (q.opBusy == '0) ? '0 : q.opBusy - 1'b1;
      d.pdCnt = q.cke ? '0 : q.pdCnt + 1'b1;
      if (q.left != '0) begin
        d.dq = wrData;
        d.dm = wrMask;
        d.left = q.left - 1'b1;
      end
      if (!q.cke) begin
        // leave on request, or when refresh would starve
        if (pulseOk && (!reqLowPower || (!q.inSelf && q.pdCnt >= CNT_W'(MAX_PD)))) begin
          d.cke = 1'b1;
          d.pulse = '0;
          d.inSelf = 1'b0;
          if (q.inSelf) begin
            d.exitCnt = CNT_W'(READ_EXIT_CLOCKS);
          end
        end
      end else if (reqLowPower && !calMode && pulseOk && q.left == '0 && q.opBusy == '0
                   && q.exitCnt == '0) begin
        d.cke = 1'b0;
        d.pulse = '0;
        if (reqSelfRefresh && q.open == '0) begin
          d.pins = ddrc_encode(DDRC_CMD_REF);
          d.inSelf = 1'b1;
        end
      end else if (ok) begin
        d.pins = ddrc_encode(reqCmd);
        d.bank = reqBank;
        d.a10 = reqA10;
        d.col = reqCol;
        d.ack = 1'b1;
        case (reqCmd)
          DDRC_CMD_ACT: d.open[reqBank] = 1'b1;
          DDRC_CMD_PRE: begin
            if (reqA10) begin
              d.open = '0;
            end else begin
              d.open[reqBank] = 1'b0;
            end
            d.opBusy = CNT_W'(OP_BUSY_CLOCKS);
          end
          DDRC_CMD_MRS: d.opBusy = CNT_W'(OP_BUSY_CLOCKS);
          DDRC_CMD_READ, DDRC_CMD_WRITE: begin
            d.left = CNT_W'(BURST);
            d.writing = !rd;
            d.bBank = reqBank; // burst bank, kept apart from later act/pre banks
          end
          default: d.opBusy = q.opBusy;
        endcase
      end
      // flopped copies for the user-facing status outputs
      d.busy = d.left != '0;
      d.lowP = !d.cke;
    end
  end

  // state register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
      q.cke <= RST_CKE;
      q.pins <= PINS_DESELECT;
      q.pulse <= CNT_W'(MIN_CKE_PULSE);
    end else begin
      q <= d;
    end
  end

  assign ifc.cke = q.cke;
  assign ifc.cmdPins = q.pins;
  assign ifc.bank = q.bank;
  assign ifc.a10 = q.a10;
  assign ifc.col = q.col;
  assign ifc.dq = q.dq;
  assign ifc.dm = q.dm;
  assign ifc.odt = q.odt;
  assign reqAck = q.ack;
  assign burstBusy = q.busy;
  assign lowPower = q.lowP;
endmodule : ddrc_controller

// ### sim/ddrc_check_properties.sv
// ddrc_check_properties: cke and command relations seen on the link
// assumes one clock; instantiated by the bench beside the interface
`timescale 1ns/10ps
module ddrc_check_properties
  import ddrc_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic cke,
  input wire logic [3:0] cmdPins,
  input wire ddrc_state_t devState,
  input wire logic odtActive,
  input wire logic illegalCmd
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [7:0] rdWait_q;

  // edges left during which reads stay barred after self refresh exit
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdWait_q <= 8'h00;
    end else if ($rose(cke) && devState == DDRC_SELF) begin
      rdWait_q <= 8'(READ_EXIT_CLOCKS - 1);
    end else if (rdWait_q != 8'h00) begin
      rdWait_q <= rdWait_q - 8'h01;
    end
  end

  // deselect or no-operation on the pins
  sequence quiet_cmd;
    cmdPins[3] || cmdPins == PINS_NOP;
  endsequence
  // cke registered high while the device sleeps in self refresh
  sequence self_exit;
    $rose(cke) && devState == DDRC_SELF;
  endsequence

  cke_pulse_a: assert property ($changed(cke) |=> $stable(cke) [*2])
    else $error("cke changed within three edges");
  cke_rise_a: assert property ($rose(cke) |-> quiet_cmd)
    else $error("cke rose with a busy command");
  cke_fall_a: assert property ($fell(cke) |-> cmdPins[3] || cmdPins == PINS_NOP
    || (cmdPins == 4'h1 && devState == DDRC_IDLE)) else $error("bad cke fall command");
  pd_kind_a: assert property ($fell(cke) && cmdPins != 4'h1 |=> devState ==
    ($past(devState) == DDRC_IDLE ? DDRC_PD_PRE : DDRC_PD_ACT)) else $error("wrong pd kind");
  self_entry_a: assert property ($fell(cke) && cmdPins == 4'h1 && devState == DDRC_IDLE
    |=> devState == DDRC_SELF) else $error("self refresh not entered");
  low_hold_a: assert property (!cke && !$past(cke) && devState inside
    {DDRC_PD_ACT, DDRC_PD_PRE, DDRC_SELF} |=> $stable(devState)) else $error("left low power");
  exit_quiet_a: assert property (self_exit |-> quiet_cmd [*8])
    else $error("command inside exit window");
  read_bar_a: assert property (rdWait_q != 8'h00 |-> cmdPins != 4'h5)
    else $error("read too soon after exit");
  odt_self_a: assert property (devState == DDRC_SELF && $past(devState) == DDRC_SELF
    |-> !odtActive) else $error("termination on in self refresh");
  no_illegal_a: assert property (!illegalCmd)
    else $error("illegal combination issued");
  busy_entry_a: assert property ($fell(cke) |-> !(devState inside {DDRC_READ, DDRC_WRITE}))
    else $error("cke fell during a burst");
endmodule : ddrc_check_properties

// ### sim/ddr2_cke_state_command_control_tb.sv
// ddr2_cke_state_command_control_tb: controller and device joined by the link
// assumes BURST of 4, exit window shortened to 8 and power down limit to 50
`timescale 1ns/10ps
module ddr2_cke_state_command_control_tb;
  import ddrc_pkg::*;
  logic clk, rstn, reqValid, reqA10, reqLowPower, reqSelfRefresh, calMode, odtReq, wrMask;
  logic reqAck, burstBusy, lowPower, illegalCmd, odtActive;
  ddrc_cmd_t reqCmd;
  ddrc_state_t devState;
  logic [BANK_W-1:0] reqBank;
  logic [COL_W-1:0] reqCol;
  logic [DATA_W-1:0] wrData;
  logic [DATA_W-1:0] mem [4];
  logic [DATA_W-1:0] expQ [$];
  logic [31:0] lfsr_q;
  int fails, total_checks, cyc, t0, tAck;

  ddrc_if link();
  ddrc_device ddrc_device_inst (.clk, .rstn, .en(1'b1), .ifc(link), .devState, .illegalCmd,
    .odtActive);
  ddrc_controller #(.NONREAD_EXIT(8), .MAX_PD(50)) ddrc_controller_inst (.clk, .rstn,
    .en(1'b1), .ifc(link), .reqValid, .reqCmd, .reqBank, .reqA10, .reqCol, .reqLowPower,
    .reqSelfRefresh, .calMode, .odtReq, .wrData, .wrMask, .reqAck, .burstBusy, .lowPower);
  ddrc_check_properties ddrc_check_properties_inst (.clk, .rstn, .cke(link.cke),
    .cmdPins(link.cmdPins), .devState, .odtActive, .illegalCmd);

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic check_state(input ddrc_state_t exp);
    check(32'(devState), 32'(exp));
  endtask : check_state

  task automatic wrap_up();
    if (fails == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  // present a request until acknowledged or the limit runs out
  task automatic issue(input ddrc_cmd_t c, input logic [2:0] b, input logic [1:0] col,
                       input int lim, input logic expAck);
    int n;
    // let an edge pass so back-to-back calls never re-raise valid in one step
    @(negedge clk);
    reqValid = 1'b1;
    reqCmd = c;
    reqBank = b;
    reqCol = col;
    reqA10 = (c == DDRC_CMD_PRE);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (reqAck !== 1'b1 && n < lim);
    reqValid = 1'b0;
    tAck = cyc;
    check(reqAck, expAck);
  endtask : issue

  // write burst to bank 1 with random beats, noting what should be stored
  task automatic write_burst(input logic [1:0] col, input logic [3:0] mask);
    issue(DDRC_CMD_WRITE, 3'h1, col, 400, 1'b1);
    for (int i = 0; i < 4; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      wrData = lfsr_q[7:0];
      wrMask = mask[i];
      if (!mask[i]) mem[2'(col + i)] = wrData;
      check(burstBusy, 1'b1);
      @(negedge clk);
    end
    check(burstBusy, 1'b0);
  endtask : write_burst

  // read burst from bank 1, optionally trying a second command mid-burst
  task automatic read_burst(input logic [1:0] col, input ddrc_cmd_t intr);
    int n;
    for (int i = 0; i < 4; i++) expQ.push_back(mem[2'(col + i)]);
    issue(DDRC_CMD_READ, 3'h1, col, 400, 1'b1);
    if (intr != DDRC_CMD_NOP) issue(intr, 3'h1, col, 2, 1'b0);
    n = 0;
    while (expQ.size() > 0 && n < 20) begin
      @(negedge clk);
      n++;
    end
    check(expQ.size(), 0);
  endtask : read_burst

  task automatic wait_lp(input logic v, input int lim);
    int n;
    n = 0;
    while (lowPower !== v && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask : wait_lp

  // clock and cycle count
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) cyc++;

  // read beats against the oldest expectation, sampled mid-cycle once settled
  always @(negedge clk) begin
    if (link.rdqValid === 1'b1) begin
      check(expQ.size() > 0, 1'b1);
      if (expQ.size() > 0) check(link.rdq, expQ.pop_front());
    end
  end

  // hang guard
  initial begin
    #(3000 * 100);
    fails++;
    wrap_up();
  end

  // main sequence
  initial begin
    {rstn, reqValid, reqA10, reqLowPower, reqSelfRefresh, calMode, odtReq, wrMask} = 8'h00;
    reqCmd = DDRC_CMD_NOP;
    reqBank = 3'h0;
    reqCol = 2'h0;
    wrData = 8'h00;
    lfsr_q = 32'h0000_6866;
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    check_state(DDRC_IDLE);
    issue(DDRC_CMD_READ, 3'h1, 2'h0, 20, 1'b0);
    issue(DDRC_CMD_ACT, 3'h1, 2'h0, 400, 1'b1);
    @(negedge clk);
    check_state(DDRC_ACTIVE);
    issue(DDRC_CMD_ACT, 3'h1, 2'h0, 20, 1'b0);
    issue(DDRC_CMD_REF, 3'h0, 2'h0, 20, 1'b0);
    issue(DDRC_CMD_MRS, 3'h0, 2'h0, 20, 1'b0);
    write_burst(2'h0, 4'h0);
    write_burst(2'h2, lfsr_q[3:0]);
    read_burst(2'h0, DDRC_CMD_WRITE);
    read_burst(2'h1, DDRC_CMD_READ);
    calMode = 1'b1;
    reqLowPower = 1'b1;
    wait_lp(1'b1, 20);
    check(lowPower, 1'b0);
    calMode = 1'b0;
    wait_lp(1'b1, 20);
    repeat (10) @(negedge clk);
    check_state(DDRC_PD_ACT);
    reqLowPower = 1'b0;
    wait_lp(1'b0, 20);
    @(negedge clk);
    check_state(DDRC_ACTIVE);
    issue(DDRC_CMD_PRE, 3'h0, 2'h0, 400, 1'b1);
    odtReq = 1'b1;
    reqLowPower = 1'b1;
    wait_lp(1'b1, 20);
    @(negedge clk);
    check_state(DDRC_PD_PRE);
    check(odtActive, 1'b1);
    wait_lp(1'b0, 80);
    check(lowPower, 1'b0);
    reqSelfRefresh = 1'b1;
    wait_lp(1'b1, 20);
    repeat (10) @(negedge clk);
    check_state(DDRC_SELF);
    check(odtActive, 1'b0);
    reqLowPower = 1'b0;
    reqSelfRefresh = 1'b0;
    wait_lp(1'b0, 20);
    t0 = cyc;
    @(negedge clk);
    check_state(DDRC_IDLE);
    issue(DDRC_CMD_ACT, 3'h1, 2'h0, 400, 1'b1);
    check(tAck - t0 >= 8, 1'b1);
    read_burst(2'h0, DDRC_CMD_NOP);
    check(tAck - t0 >= 200, 1'b1);
    repeat (5) @(negedge clk);
    wrap_up();
  end
endmodule : ddr2_cke_state_command_control_tb
